// ### iab_bridge_regs.sv
// Indirect access and bridge control register group
//
// Behaviour
// - target select 000 off, 100 receiver, 101 transmitter
// - analog auto-increment adds one per access
// - direction bit 0 writes, 1 reads
// - eight-bit offset addresses every indirect access
// - data register write performs indirect write
// - data register read returns indirect read
// - internal target 10 config, 11 die identity
// - internal auto-increment adds one per read
// - start bit begins internal read into data
// - start bit self-clears when read completes
// - internal bus works only while enabled
// - map select 0 SPWG, 1 OpenLDI
// - map and pixel mode load from straps
// - pixel mode 0 dual, 1 single
// - swap uses secondary or exchanges ports
// - reload bit reloads configuration from memory
// - reload bit self-clears when reload done is signalled
// - configuration done precedes initialization done
// - status bit five shows pending protection interrupt
module iab_bridge_regs
    import iab_pkg::*;
(
    input  wire logic                    I_MCLK,
    input  wire logic                    I_RST_N,
    // Register port from the serial slave
    input  wire logic [ADDR_W-1:0]       I_REG_ADDR,
    input  wire logic                    I_REG_WR,
    input  wire logic [DATA_W-1:0]       I_REG_WDATA,
    input  wire logic                    I_REG_RD,
    output logic                         O_REG_READY,
    output logic                         O_REG_RVALID,
    output logic [DATA_W-1:0]            O_REG_RDATA,
    // Analog block indirect port
    output logic                         O_ANA_RX_SEL,
    output logic                         O_ANA_TX_SEL,
    output logic [ADDR_W-1:0]            O_ANA_ADDR,
    output logic [DATA_W-1:0]            O_ANA_WDATA,
    output logic                         O_ANA_WR,
    output logic                         O_ANA_RD,
    input  wire logic                    I_ANA_ACK,
    input  wire logic [DATA_W-1:0]       I_ANA_RDATA,
    // Internal configuration bus
    output logic                         O_IBUS_REQ,
    output logic [IBUS_SEL_W-1:0]        O_IBUS_SEL,
    output logic [ADDR_W-1:0]            O_IBUS_ADDR,
    input  wire logic                    I_IBUS_ACK,
    input  wire logic [DATA_W-1:0]       I_IBUS_RDATA,
    // Video receiver setup
    input  wire logic                    I_MODE_STRAP_ZERO,
    input  wire logic                    I_MODE_STRAP_ONE,
    output logic                         O_INPUT_BIT_MAP_SELECT,
    output logic                         O_INPUT_PIXEL_MODE,
    output logic                         O_USE_SECONDARY_PORT,
    output logic                         O_EXCHANGE_PORTS,
    // Configuration loader and status sources
    output logic                         O_CFG_RELOAD,
    input  wire logic                    I_RELOAD_DONE,
    input  wire logic                    I_CFG_DONE,
    input  wire logic                    I_INIT_DONE,
    input  wire logic                    I_PROT_IRQ
);
    import iab_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ANA_WR, ST_ANA_RD} iab_state_t;

    iab_state_t              state;
    iab_state_t              next_state;

    logic [ANA_SEL_W-1:0]    ana_sel;
    logic                    ana_inc;
    logic                    ana_dir;
    logic [ADDR_W-1:0]       ana_ofs;
    logic [DATA_W-1:0]       ana_data;

    logic [IBUS_SEL_W-1:0]   ibus_sel;
    logic                    ibus_inc;
    logic                    ibus_start;
    logic                    ibus_en;
    logic [ADDR_W-1:0]       ibus_addr;
    logic [DATA_W-1:0]       ibus_data;

    logic                    map_sel;
    logic                    pix_mode;
    logic                    port_swap;
    logic                    reload;
    logic                    strap_taken;

    logic                    sts_prot;
    logic                    sts_cfg;
    logic                    sts_init;

    logic                    ibus_busy;
    logic                    ibus_done;
    logic [DATA_W-1:0]       ibus_rd_byte;

    // Access decode
    wire take_wr     = I_REG_WR && O_REG_READY;
    wire take_rd     = I_REG_RD && O_REG_READY && !I_REG_WR;
    wire wr_ana_ctl  = take_wr && (I_REG_ADDR == OFS_ANA_CTL);
    wire wr_ana_ofs  = take_wr && (I_REG_ADDR == OFS_ANA_OFS);
    wire wr_ana_data = take_wr && (I_REG_ADDR == OFS_ANA_DATA);
    wire wr_ibus_ctl = take_wr && (I_REG_ADDR == OFS_IBUS_CTL);
    wire wr_ibus_adr = take_wr && (I_REG_ADDR == OFS_IBUS_ADDR);
    wire wr_ibus_dat = take_wr && (I_REG_ADDR == OFS_IBUS_DATA);
    wire wr_brg_ctl  = take_wr && (I_REG_ADDR == OFS_BRG_CTL);
    wire rd_ana_data = take_rd && (I_REG_ADDR == OFS_ANA_DATA);

    // Only two select codes reach a block; the rest stay inert
    wire sel_rx    = (ana_sel == ANA_SEL_RX);
    wire sel_tx    = (ana_sel == ANA_SEL_TX);
    wire ana_valid = sel_rx || sel_tx;

    // Direction bit gates which kind of indirect access a data access makes
    wire ana_wr_go = wr_ana_data && ana_valid && !ana_dir;
    wire ana_rd_go = rd_ana_data && ana_valid && ana_dir;
    wire ana_fin   = (state != ST_IDLE) && I_ANA_ACK;

    wire ibus_tgt_ok = ibus_sel[1];
    wire ibus_launch = ibus_start && ibus_en && ibus_tgt_ok && !ibus_busy && !ibus_done;
    // A start that cannot run is dropped rather than left pending forever
    wire ibus_drop   = ibus_start && !(ibus_en && ibus_tgt_ok) && !ibus_busy;
    wire set_start   = wr_ibus_ctl && I_REG_WDATA[IBUS_START_BIT];
    wire set_reload  = wr_brg_ctl && I_REG_WDATA[BRG_RELOAD_BIT];

    wire [ADDR_W-1:0] ana_ofs_inc  = ana_ofs + ADDR_INC;
    wire [ADDR_W-1:0] ibus_adr_inc = ibus_addr + ADDR_INC;

    wire [7:0] ana_ctl_rd  = {3'h0, ana_sel, ana_inc, ana_dir};
    wire [7:0] ibus_ctl_rd = {3'h0, ibus_sel, ibus_inc, ibus_start, ibus_en};
    wire [7:0] brg_ctl_rd  = {map_sel, pix_mode, port_swap, 3'h0, reload, 1'b0};
    wire [7:0] brg_sts_rd  = {2'h0, sts_prot, sts_init, 1'b0, sts_cfg, 2'h0};

    logic [DATA_W-1:0] reg_mux;

    always_comb
    begin
        case (I_REG_ADDR)
            OFS_ANA_CTL:   reg_mux = ana_ctl_rd;
            OFS_ANA_OFS:   reg_mux = ana_ofs;
            OFS_ANA_DATA:  reg_mux = ana_data;
            OFS_IBUS_CTL:  reg_mux = ibus_ctl_rd;
            OFS_IBUS_ADDR: reg_mux = ibus_addr;
            OFS_IBUS_DATA: reg_mux = ibus_data;
            OFS_BRG_CTL:   reg_mux = brg_ctl_rd;
            OFS_BRG_STS:   reg_mux = brg_sts_rd;
            default:       reg_mux = '0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (ana_wr_go)
                    next_state = ST_ANA_WR;
                else if (ana_rd_go)
                    next_state = ST_ANA_RD;
            end
            ST_ANA_WR,
            ST_ANA_RD:
            begin
                if (I_ANA_ACK)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Port stalls for the whole analog access
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state        <= ST_IDLE;
            O_REG_READY  <= 1'b0;
            O_REG_RVALID <= 1'b0;
            O_REG_RDATA  <= '0;
            O_ANA_WR     <= 1'b0;
            O_ANA_RD     <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            O_REG_READY  <= (next_state == ST_IDLE);
            O_ANA_WR     <= (next_state == ST_ANA_WR);
            O_ANA_RD     <= (next_state == ST_ANA_RD);
            O_REG_RVALID <= (take_rd && !ana_rd_go) || (state == ST_ANA_RD && I_ANA_ACK);
            if (state == ST_ANA_RD && I_ANA_ACK)
                O_REG_RDATA <= I_ANA_RDATA;
            else if (take_rd)
                O_REG_RDATA <= reg_mux;
        end
    end

    // Analog indirect window
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ana_sel  <= RST_ANA_CTL[ANA_SEL_LSB +: ANA_SEL_W];
            ana_inc  <= RST_ANA_CTL[ANA_INC_BIT];
            ana_dir  <= RST_ANA_CTL[ANA_DIR_BIT];
            ana_ofs  <= RST_ANA_OFS;
            ana_data <= RST_ANA_DATA;
        end
        else
        begin
            if (wr_ana_ctl)
            begin
                ana_sel <= I_REG_WDATA[ANA_SEL_LSB +: ANA_SEL_W];
                ana_inc <= I_REG_WDATA[ANA_INC_BIT];
                ana_dir <= I_REG_WDATA[ANA_DIR_BIT];
            end
            if (wr_ana_ofs)
                ana_ofs <= I_REG_WDATA;
            else if (ana_fin && ana_inc)
                ana_ofs <= ana_ofs_inc;
            if (wr_ana_data)
                ana_data <= I_REG_WDATA;
            else if (state == ST_ANA_RD && I_ANA_ACK)
                ana_data <= I_ANA_RDATA;
        end
    end

    // Block selects, offset and write data as seen by the analog blocks
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_ANA_RX_SEL <= 1'b0;
            O_ANA_TX_SEL <= 1'b0;
            O_ANA_ADDR   <= '0;
            O_ANA_WDATA  <= '0;
        end
        else if (state == ST_IDLE)
        begin
            // Held steady while an access is in flight
            O_ANA_RX_SEL <= (ana_wr_go || ana_rd_go) && sel_rx;
            O_ANA_TX_SEL <= (ana_wr_go || ana_rd_go) && sel_tx;
            O_ANA_ADDR   <= ana_ofs;
            O_ANA_WDATA  <= wr_ana_data ? I_REG_WDATA : ana_data;
        end
        else if (I_ANA_ACK)
        begin
            O_ANA_RX_SEL <= 1'b0;
            O_ANA_TX_SEL <= 1'b0;
        end
    end

    // Internal bus window
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ibus_sel   <= RST_IBUS_CTL[IBUS_SEL_LSB +: IBUS_SEL_W];
            ibus_inc   <= RST_IBUS_CTL[IBUS_INC_BIT];
            ibus_start <= RST_IBUS_CTL[IBUS_START_BIT];
            ibus_en    <= RST_IBUS_CTL[IBUS_EN_BIT];
            ibus_addr  <= RST_IBUS_ADDR;
            ibus_data  <= RST_IBUS_DATA;
        end
        else
        begin
            if (wr_ibus_ctl)
            begin
                ibus_sel <= I_REG_WDATA[IBUS_SEL_LSB +: IBUS_SEL_W];
                ibus_inc <= I_REG_WDATA[IBUS_INC_BIT];
                ibus_en  <= I_REG_WDATA[IBUS_EN_BIT];
            end
            // A new start written as the last read ends is kept
            if (set_start)
                ibus_start <= 1'b1;
            else if (ibus_done || ibus_drop)
                ibus_start <= 1'b0;
            // Address is latched at launch, so a late write cannot tear a read
            if (wr_ibus_adr)
                ibus_addr <= I_REG_WDATA;
            else if (ibus_done && ibus_inc)
                ibus_addr <= ibus_adr_inc;
            if (ibus_done)
                ibus_data <= ibus_rd_byte;
            else if (wr_ibus_dat)
                ibus_data <= I_REG_WDATA;
        end
    end

    iab_ibus_reader u_ibus_reader (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_start (ibus_launch),
        .i_sel   (ibus_sel),
        .i_addr  (ibus_addr),
        .i_ack   (I_IBUS_ACK),
        .i_rdata (I_IBUS_RDATA),
        .o_req   (O_IBUS_REQ),
        .o_sel   (O_IBUS_SEL),
        .o_addr  (O_IBUS_ADDR),
        .o_busy  (ibus_busy),
        .o_done  (ibus_done),
        .o_data  (ibus_rd_byte)
    );

    // Bridge control; straps are caught on the first edge after release
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            strap_taken  <= 1'b0;
            map_sel      <= 1'b0;
            pix_mode     <= 1'b0;
            port_swap    <= RST_SWAP;
            reload       <= RST_RELOAD;
            O_CFG_RELOAD <= 1'b0;
        end
        else
        begin
            strap_taken  <= 1'b1;
            O_CFG_RELOAD <= set_reload;
            if (!strap_taken)
            begin
                map_sel  <= I_MODE_STRAP_ONE;
                pix_mode <= I_MODE_STRAP_ZERO;
            end
            else if (wr_brg_ctl)
            begin
                map_sel   <= I_REG_WDATA[BRG_MAP_BIT];
                pix_mode  <= I_REG_WDATA[BRG_MODE_BIT];
                port_swap <= I_REG_WDATA[BRG_SWAP_BIT];
            end
            if (set_reload)
                reload <= 1'b1;
            else if (I_RELOAD_DONE)
                reload <= 1'b0;
        end
    end

    // Receiver steering and status sampling
    always_ff @(posedge I_MCLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_INPUT_BIT_MAP_SELECT <= 1'b0;
            O_INPUT_PIXEL_MODE     <= 1'b0;
            O_USE_SECONDARY_PORT   <= 1'b0;
            O_EXCHANGE_PORTS       <= 1'b0;
            sts_prot               <= 1'b0;
            sts_cfg                <= 1'b0;
            sts_init               <= 1'b0;
        end
        else
        begin
            O_INPUT_BIT_MAP_SELECT <= map_sel;
            O_INPUT_PIXEL_MODE     <= pix_mode;
            O_USE_SECONDARY_PORT   <= port_swap && pix_mode;
            O_EXCHANGE_PORTS       <= port_swap && !pix_mode;
            sts_prot               <= I_PROT_IRQ;
            sts_cfg                <= I_CFG_DONE;
            // Initialization never reports done ahead of configuration
            sts_init               <= I_INIT_DONE && I_CFG_DONE;
        end
    end
endmodule

// ### iab_pkg.sv
// Constants for the indirect access bridge register group
package iab_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_ANA_CTL   = 8'h40;
    localparam logic [7:0] OFS_ANA_OFS   = 8'h41;
    localparam logic [7:0] OFS_ANA_DATA  = 8'h42;
    localparam logic [7:0] OFS_IBUS_CTL  = 8'h48;
    localparam logic [7:0] OFS_IBUS_ADDR = 8'h49;
    localparam logic [7:0] OFS_IBUS_DATA = 8'h4b;
    localparam logic [7:0] OFS_BRG_CTL   = 8'h4f;
    localparam logic [7:0] OFS_BRG_STS   = 8'h50;

    // Reset values
    localparam logic [7:0] RST_ANA_CTL   = 8'h00;
    localparam logic [7:0] RST_ANA_OFS   = 8'h00;
    localparam logic [7:0] RST_ANA_DATA  = 8'h00;
    localparam logic [7:0] RST_IBUS_CTL  = 8'h00;
    localparam logic [7:0] RST_IBUS_ADDR = 8'h00;
    localparam logic [7:0] RST_IBUS_DATA = 8'h00;

    // Analog control fields
    localparam int ANA_SEL_LSB = 2;
    localparam int ANA_SEL_W   = 3;
    localparam int ANA_INC_BIT = 1;
    localparam int ANA_DIR_BIT = 0;
    localparam logic [2:0] ANA_SEL_OFF = 3'h0;
    localparam logic [2:0] ANA_SEL_RX  = 3'h4;
    localparam logic [2:0] ANA_SEL_TX  = 3'h5;

    // Internal bus control fields
    localparam int IBUS_SEL_LSB   = 3;
    localparam int IBUS_SEL_W     = 2;
    localparam int IBUS_INC_BIT   = 2;
    localparam int IBUS_START_BIT = 1;
    localparam int IBUS_EN_BIT    = 0;
    localparam logic [1:0] IBUS_SEL_CFG = 2'h2;
    localparam logic [1:0] IBUS_SEL_ID  = 2'h3;

    // Bridge control and status fields
    localparam int BRG_MAP_BIT    = 7;
    localparam int BRG_MODE_BIT   = 6;
    localparam int BRG_SWAP_BIT   = 5;
    localparam int BRG_RELOAD_BIT = 1;
    localparam int STS_PROT_BIT   = 5;
    localparam int STS_INIT_BIT   = 4;
    localparam int STS_CFG_BIT    = 2;
    localparam logic RST_SWAP     = 1'b0;
    localparam logic RST_RELOAD   = 1'b0;

    localparam logic [7:0] ADDR_INC = 8'h01;
endpackage

// ### iab_ibus_reader.sv
// Single-read sequencer for the internal configuration bus
module iab_ibus_reader
    import iab_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_start,
    input  wire logic [IBUS_SEL_W-1:0]   i_sel,
    input  wire logic [ADDR_W-1:0]       i_addr,
    input  wire logic                    i_ack,
    input  wire logic [DATA_W-1:0]       i_rdata,
    output logic                         o_req,
    output logic [IBUS_SEL_W-1:0]        o_sel,
    output logic [ADDR_W-1:0]            o_addr,
    output logic                         o_busy,
    output logic                         o_done,
    output logic [DATA_W-1:0]            o_data
);
    import iab_pkg::*;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_req  <= 1'b0;
            o_sel  <= '0;
            o_addr <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_data <= '0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start && !o_busy)
            begin
                // Target and address frozen for the whole read
                o_req  <= 1'b1;
                o_sel  <= i_sel;
                o_addr <= i_addr;
                o_busy <= 1'b1;
            end
            else if (o_busy && i_ack)
            begin
                o_req  <= 1'b0;
                o_busy <= 1'b0;
                o_done <= 1'b1;
                o_data <= i_rdata;
            end
        end
    end
endmodule

// ### iab_bridge_regs_asserts.sv
// Port-level assertions for the bridge register group
module iab_regs_asserts
    import iab_pkg::*;
(
    input wire logic                  I_MCLK,
    input wire logic                  I_RST_N,
    input wire logic [ADDR_W-1:0]     I_REG_ADDR,
    input wire logic                  I_REG_WR,
    input wire logic [DATA_W-1:0]     I_REG_WDATA,
    input wire logic                  I_REG_RD,
    input wire logic                  O_REG_READY,
    input wire logic                  O_REG_RVALID,
    input wire logic [DATA_W-1:0]     O_REG_RDATA,
    input wire logic                  O_ANA_RX_SEL,
    input wire logic                  O_ANA_TX_SEL,
    input wire logic [ADDR_W-1:0]     O_ANA_ADDR,
    input wire logic [DATA_W-1:0]     O_ANA_WDATA,
    input wire logic                  O_ANA_WR,
    input wire logic                  O_ANA_RD,
    input wire logic                  I_ANA_ACK,
    input wire logic [DATA_W-1:0]     I_ANA_RDATA,
    input wire logic                  O_IBUS_REQ,
    input wire logic [IBUS_SEL_W-1:0] O_IBUS_SEL,
    input wire logic [ADDR_W-1:0]     O_IBUS_ADDR,
    input wire logic                  I_IBUS_ACK,
    input wire logic                  O_USE_SECONDARY_PORT,
    input wire logic                  O_EXCHANGE_PORTS,
    input wire logic                  O_CFG_RELOAD
);
    wire rld_take = O_REG_READY && I_REG_WR && I_REG_ADDR == OFS_BRG_CTL && I_REG_WDATA[BRG_RELOAD_BIT];
    wire ana_busy = O_ANA_WR || O_ANA_RD;

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    property p_sel_one; !(O_ANA_RX_SEL && O_ANA_TX_SEL); endproperty
    a_sel_one: assert property (p_sel_one) else $error("both analog targets selected");
    property p_sel_live; ana_busy |-> (O_ANA_RX_SEL || O_ANA_TX_SEL); endproperty
    a_sel_live: assert property (p_sel_live) else $error("analog access without target");
    property p_wr_hold; O_ANA_WR && !I_ANA_ACK |=> O_ANA_WR && $stable(O_ANA_WDATA) && $stable(O_ANA_ADDR); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("analog write dropped early");
    property p_rd_end; O_ANA_RD && I_ANA_ACK |=> !O_ANA_RD && O_REG_RVALID && O_REG_RDATA == $past(I_ANA_RDATA); endproperty
    a_rd_end: assert property (p_rd_end) else $error("analog read data not returned");
    property p_busy_stall; ana_busy |-> !O_REG_READY; endproperty
    a_busy_stall: assert property (p_busy_stall) else $error("port ready during analog access");
    property p_ib_hold; O_IBUS_REQ && !I_IBUS_ACK |=> O_IBUS_REQ && $stable(O_IBUS_ADDR) && $stable(O_IBUS_SEL); endproperty
    a_ib_hold: assert property (p_ib_hold) else $error("internal read request unstable");
    property p_ib_sel; O_IBUS_REQ |-> O_IBUS_SEL[1]; endproperty
    a_ib_sel: assert property (p_ib_sel) else $error("internal read to reserved target");
    property p_ib_end; O_IBUS_REQ && I_IBUS_ACK |=> !O_IBUS_REQ; endproperty
    a_ib_end: assert property (p_ib_end) else $error("internal request held after ack");
    property p_reload; O_CFG_RELOAD == $past(rld_take); endproperty
    a_reload: assert property (p_reload) else $error("reload pulse mismatch");
    property p_swap; !(O_USE_SECONDARY_PORT && O_EXCHANGE_PORTS); endproperty
    a_swap: assert property (p_swap) else $error("swap outputs both high");
    property p_rd_ans; O_REG_READY && I_REG_RD && !I_REG_WR && I_REG_ADDR != OFS_ANA_DATA |=> O_REG_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("register read not answered");
endmodule

bind iab_bridge_regs iab_regs_asserts iab_regs_asserts_inst (.*);

// ### testbench.sv
// Self-checking testbench for the bridge register group
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iab_pkg::*;
    logic       I_MCLK, I_RST_N, I_REG_WR, I_REG_RD, I_ANA_ACK, I_IBUS_ACK, I_MODE_STRAP_ZERO, I_MODE_STRAP_ONE;
    logic       I_RELOAD_DONE, I_CFG_DONE, I_INIT_DONE, I_PROT_IRQ, O_REG_READY, O_REG_RVALID, O_IBUS_REQ;
    logic       O_ANA_RX_SEL, O_ANA_TX_SEL, O_ANA_WR, O_ANA_RD, O_INPUT_BIT_MAP_SELECT, O_INPUT_PIXEL_MODE;
    logic       O_USE_SECONDARY_PORT, O_EXCHANGE_PORTS, O_CFG_RELOAD;
    logic [7:0] I_REG_ADDR, I_REG_WDATA, I_ANA_RDATA, I_IBUS_RDATA, O_REG_RDATA, O_ANA_ADDR, O_ANA_WDATA, O_IBUS_ADDR;
    logic [1:0] O_IBUS_SEL;
    int         err_total, num_checks, ana_cnt, ibus_cnt, rld_cnt, adly = 1, idly = 1;
    logic [31:0] seed = 32'd99;
    logic [7:0] exp_q[$];
    logic [7:0] ana_a, ana_d, ib_a;
    logic [1:0] ana_s, ib_s;

    iab_bridge_regs iab_bridge_regs_inst (.*);

    initial
    begin
        I_MCLK = 1'b0;
        forever #2 I_MCLK = ~I_MCLK;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] ana_val(input logic [7:0] a, input logic tx);
        return a ^ (tx ? 8'ha5 : 8'h5a);
    endfunction

    function automatic logic [7:0] ib_val(input logic [7:0] a, input logic [1:0] s);
        return a ^ {6'h00, s} ^ 8'h33;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic idle(input int n);
        I_REG_WR = 1'b0;
        I_REG_RD = 1'b0;
        repeat (n) @(negedge I_MCLK);
    endtask

    // Strobes stay up between accesses; idle() drops them
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (O_REG_READY !== 1'b1)
        begin
            @(negedge I_MCLK);
            n++;
            if (n > 64)
            begin
                err_total++;
                final_report();
            end
        end
        I_REG_WR = w;
        I_REG_RD = !w;
        I_REG_ADDR = a;
        I_REG_WDATA = d;
        if (!w)
            exp_q.push_back(d);
        @(negedge I_MCLK);
    endtask

    always @(negedge I_MCLK)
        if (O_REG_RVALID === 1'b1)
            check(O_REG_RDATA, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

    always @(negedge I_MCLK)
        if (O_CFG_RELOAD === 1'b1)
            rld_cnt++;

    // Responders stall at random; idle data churns
    initial
    begin
        I_ANA_ACK = 1'b0;
        I_ANA_RDATA = 8'h00;
        I_IBUS_ACK = 1'b0;
        I_IBUS_RDATA = 8'h00;
        forever
        begin
            @(negedge I_MCLK);
            I_ANA_RDATA = ~I_ANA_RDATA;
            I_IBUS_RDATA = ~I_IBUS_RDATA;
            if (I_ANA_ACK)
                I_ANA_ACK = 1'b0;
            else if ((O_ANA_WR | O_ANA_RD) === 1'b1 && adly > 0)
                adly--;
            else if ((O_ANA_WR | O_ANA_RD) === 1'b1)
            begin
                I_ANA_ACK = 1'b1;
                I_ANA_RDATA = ana_val(O_ANA_ADDR, O_ANA_TX_SEL);
                ana_a = O_ANA_ADDR;
                ana_d = O_ANA_WDATA;
                ana_s = {O_ANA_TX_SEL, O_ANA_RX_SEL};
                ana_cnt++;
                adly = int'(rnd() % 3);
            end
            if (I_IBUS_ACK)
                I_IBUS_ACK = 1'b0;
            else if (O_IBUS_REQ === 1'b1 && idly > 0)
                idly--;
            else if (O_IBUS_REQ === 1'b1)
            begin
                I_IBUS_ACK = 1'b1;
                I_IBUS_RDATA = ib_val(O_IBUS_ADDR, O_IBUS_SEL);
                ib_a = O_IBUS_ADDR;
                ib_s = O_IBUS_SEL;
                ibus_cnt++;
                idly = int'(rnd() % 3);
            end
        end
    end

    initial
    begin
        logic [7:0] rst_ofs[7] = '{OFS_ANA_CTL, OFS_ANA_OFS, OFS_ANA_DATA, OFS_IBUS_CTL,
                                   OFS_IBUS_ADDR, OFS_IBUS_DATA, 8'h45};
        logic [2:0] sels[4] = '{ANA_SEL_RX, ANA_SEL_TX, ANA_SEL_OFF, 3'h6};
        logic [1:0] isel[4] = '{IBUS_SEL_CFG, IBUS_SEL_ID, 2'h1, IBUS_SEL_CFG};
        logic [7:0] b;
        logic       v;
        int         n;
        {I_RST_N, I_REG_WR, I_REG_RD, I_RELOAD_DONE, I_CFG_DONE, I_INIT_DONE, I_PROT_IRQ} = 7'h00;
        {I_REG_ADDR, I_REG_WDATA} = 16'h0000;
        I_MODE_STRAP_ONE = 1'b1;
        I_MODE_STRAP_ZERO = 1'b0;
        repeat (4) @(negedge I_MCLK);
        I_RST_N = 1'b1;
        idle(3);
        check({6'h00, O_INPUT_BIT_MAP_SELECT, O_INPUT_PIXEL_MODE}, 8'h02);
        foreach (rst_ofs[i])
            acc(1'b0, rst_ofs[i], 8'h00);
        acc(1'b0, OFS_BRG_CTL, 8'h80);
        acc(1'b0, OFS_BRG_STS, 8'h00);
        acc(1'b1, OFS_ANA_CTL, 8'he0);
        acc(1'b0, OFS_ANA_CTL, 8'h00);
        acc(1'b1, OFS_BRG_CTL, 8'h1d);
        acc(1'b0, OFS_BRG_CTL, 8'h00);
        acc(1'b1, 8'h45, 8'h77);
        acc(1'b0, 8'h45, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            v = k < 2;
            b = 8'(rnd());
            n = ana_cnt;
            acc(1'b1, OFS_ANA_CTL, {3'h0, sels[k], k != 1, 1'b0});
            acc(1'b1, OFS_ANA_OFS, 8'hfe);
            acc(1'b1, OFS_ANA_DATA, b);
            acc(1'b0, OFS_ANA_OFS, k == 0 ? 8'hff : 8'hfe);
            acc(1'b0, OFS_ANA_DATA, b);
            if (v)
                check({ana_s, 6'h00} ^ ana_a ^ ana_d, {(k == 1), (k == 0), 6'h00} ^ 8'hfe ^ b);
            acc(1'b1, OFS_ANA_CTL, {3'h0, sels[k], k != 1, 1'b1});
            acc(1'b0, OFS_ANA_DATA, v ? ana_val(k == 0 ? 8'hff : 8'hfe, k == 1) : b);
            acc(1'b0, OFS_ANA_OFS, k == 0 ? 8'h00 : 8'hfe);
            check(8'(ana_cnt - n), v ? 8'h02 : 8'h00);
        end
        for (int k = 0; k < 4; k++)
        begin
            v = k < 2;
            b = 8'(rnd());
            n = ibus_cnt;
            acc(1'b1, OFS_IBUS_ADDR, b);
            acc(1'b1, OFS_IBUS_CTL, {3'h0, isel[k], k != 1, 1'b1, k != 3});
            idle(1);
            for (int t = 0; t < 20 && ibus_cnt == n; t++)
                @(negedge I_MCLK);
            idle(3);
            acc(1'b0, OFS_IBUS_CTL, {3'h0, isel[k], k != 1, 1'b0, k != 3});
            acc(1'b0, OFS_IBUS_ADDR, k == 0 ? b + 8'h01 : b);
            if (v)
                acc(1'b0, OFS_IBUS_DATA, ib_val(b, isel[k]));
            check(8'(ibus_cnt - n), v ? 8'h01 : 8'h00);
            if (v)
                check({ib_s, 6'h00} ^ ib_a, {isel[k], 6'h00} ^ b);
        end
        acc(1'b1, OFS_BRG_CTL, 8'h60);
        idle(3);
        check({4'h0, O_USE_SECONDARY_PORT, O_EXCHANGE_PORTS, O_INPUT_BIT_MAP_SELECT, O_INPUT_PIXEL_MODE}, 8'h09);
        acc(1'b1, OFS_BRG_CTL, 8'ha0);
        idle(3);
        check({4'h0, O_USE_SECONDARY_PORT, O_EXCHANGE_PORTS, O_INPUT_BIT_MAP_SELECT, O_INPUT_PIXEL_MODE}, 8'h06);
        n = rld_cnt;
        acc(1'b1, OFS_BRG_CTL, 8'h02);
        acc(1'b0, OFS_BRG_CTL, 8'h02);
        idle(2);
        check(8'(rld_cnt - n), 8'h01);
        I_RELOAD_DONE = 1'b1;
        idle(1);
        I_RELOAD_DONE = 1'b0;
        acc(1'b0, OFS_BRG_CTL, 8'h00);
        I_CFG_DONE = 1'b1;
        idle(2);
        acc(1'b0, OFS_BRG_STS, 8'h04);
        I_INIT_DONE = 1'b1;
        idle(2);
        acc(1'b0, OFS_BRG_STS, 8'h14);
        I_CFG_DONE = 1'b0;
        I_PROT_IRQ = 1'b1;
        idle(2);
        acc(1'b0, OFS_BRG_STS, 8'h20);
        idle(4);
        check(8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule
